//--- shared/scan_port_pkg.sv
// Constants and types for the scan test port with emulation pins
// What this block does
// - Test reset high gives scan control
// - Test reset low: functional mode, ignore inputs
// - Rising test clock samples mode and data
// - Data output changes on falling edge only
// - Data output driven only while shifting
// - Disable needs reset 0, pin a 1, b 0
// - Reset high: emulator pins are scan-directed interrupts
// - Disable raises the outputs_disabled flag; it gates no driver itself
package scan_port_pkg;
  localparam int IR_WIDTH = 4;
  localparam int DR_WIDTH = 32;
  localparam int IR_CAPTURE_BITS = 1;
  localparam logic [3:0] IR_RESET = 4'hF;
  localparam logic [3:0] INS_BYPASS = 4'hF;
  localparam logic [3:0] INS_EMU_CTRL = 4'h2;
  localparam logic [3:0] INS_USER_DATA = 4'h1;
  localparam logic [3:0] INS_IDCODE = 4'h3;
  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h1234_5671;
  localparam logic [3:0] EMU_CTRL_RESET = 4'h0;
  localparam logic [31:0] USER_DATA_RESET = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;
endpackage

//--- verilog/pin_sync.sv
// Two-flop synchroniser bank for the test-port pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- verilog/scan_test_port.sv
// Test access port controller and emulation pin handling
`timescale 1ns/100ps
module scan_test_port
  import scan_port_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic test_reset,
  input wire logic test_clock,
  input wire logic test_mode_select,
  input wire logic test_data_in,
  output logic test_data_out,
  output logic test_data_out_oe,
  input wire logic emulator_event_pin_a_in,
  output logic emulator_event_pin_a_out,
  output logic emulator_event_pin_a_oe,
  input wire logic emulator_event_pin_b_output_disable_in,
  output logic emulator_event_pin_b_output_disable_out,
  output logic emulator_event_pin_b_output_disable_oe,
  input wire logic emu_event_a_send,
  input wire logic emu_event_b_send,
  output logic emu_event_a_seen,
  output logic emu_event_b_seen,
  output logic scan_control,
  output logic outputs_disabled
);
  logic [5:0] raw_pins;
  logic [5:0] sync_pins;
  assign raw_pins = {test_reset, test_clock, test_mode_select, test_data_in,
                     emulator_event_pin_a_in, emulator_event_pin_b_output_disable_in};

  pin_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  wire trst_s = sync_pins[5];
  wire tck_s = sync_pins[4];
  wire tms_s = sync_pins[3];
  wire tdi_s = sync_pins[2];
  wire pin_a_s = sync_pins[1];
  wire pin_b_s = sync_pins[0];

  logic tck_prev_q;
  tap_state_e state_q, state_d;
  logic [IR_WIDTH-1:0] ir_shift_q, ir_q;
  logic [DR_WIDTH-1:0] dr_shift_q;
  logic [DR_WIDTH-1:0] user_data_q;
  logic [3:0] emu_ctrl_q;
  logic bypass_q;
  logic tdo_q, tdo_oe_q;
  logic scan_q, off_q;
  logic a_out_q, a_oe_q, b_out_q, b_oe_q, a_seen_q, b_seen_q;

  // Scan logic runs only with test reset high; low holds everything idle
  wire scan_on = trst_s;
  wire tck_rise = scan_on & tck_s & ~tck_prev_q;
  wire tck_fall = scan_on & ~tck_s & tck_prev_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TEST_LOGIC_RESET: state_d = tms_s ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE: state_d = tms_s ? SELECT_DR : RUN_IDLE;
      SELECT_DR: state_d = tms_s ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: state_d = tms_s ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: state_d = tms_s ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: state_d = tms_s ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: state_d = tms_s ? SELECT_DR : RUN_IDLE;
      SELECT_IR: state_d = tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: state_d = tms_s ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: state_d = tms_s ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: state_d = tms_s ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: state_d = tms_s ? SELECT_DR : RUN_IDLE;
      default: state_d = TEST_LOGIC_RESET;
    endcase
  end

  wire sel_bypass = (ir_q == INS_BYPASS);
  wire sel_emu = (ir_q == INS_EMU_CTRL);
  wire sel_user = (ir_q == INS_USER_DATA);
  wire sel_id = (ir_q == INS_IDCODE);
  wire shifting = (state_q == SHIFT_DR) | (state_q == SHIFT_IR);
  wire [IR_WIDTH-1:0] ir_capture = {{(IR_WIDTH-2){1'b0}}, 2'b01};
  wire [DR_WIDTH-1:0] dr_capture = sel_id ? ID_VALUE :
                                   sel_user ? user_data_q :
                                   sel_emu ? {28'h0000000, emu_ctrl_q} : '0;
  wire dr_lsb = sel_bypass ? bypass_q : dr_shift_q[0];
  wire serial_bit = (state_q == SHIFT_IR) ? ir_shift_q[0] : dr_lsb;
  // Identification and user data are full-width paths; control is four bits
  wire dr_full = sel_user | sel_id;
  wire [DR_WIDTH-1:0] dr_shifted = dr_full ? {tdi_s, dr_shift_q[DR_WIDTH-1:1]} :
                                   {28'h0000000, tdi_s, dr_shift_q[3:1]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= TEST_LOGIC_RESET;
    end else if (!scan_on) begin
      state_q <= TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_shift_q <= IR_RESET;
      ir_q <= IR_RESET;
    end else if (!scan_on || (tck_rise && state_q == TEST_LOGIC_RESET)) begin
      ir_q <= IR_RESET;
    end else if (tck_rise) begin
      if (state_q == CAPTURE_IR) ir_shift_q <= ir_capture;
      if (state_q == SHIFT_IR) ir_shift_q <= {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
      if (state_q == UPDATE_IR) ir_q <= ir_shift_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dr_shift_q <= USER_DATA_RESET;
      bypass_q <= 1'b0;
      user_data_q <= USER_DATA_RESET;
      emu_ctrl_q <= EMU_CTRL_RESET;
    end else if (!scan_on) begin
      emu_ctrl_q <= EMU_CTRL_RESET;
    end else if (tck_rise) begin
      if (state_q == CAPTURE_DR) begin
        dr_shift_q <= dr_capture;
        bypass_q <= 1'b0;
      end
      if (state_q == SHIFT_DR) begin
        dr_shift_q <= dr_shifted;
        bypass_q <= tdi_s;
      end
      if (state_q == UPDATE_DR && sel_user) user_data_q <= dr_shift_q;
      if (state_q == UPDATE_DR && sel_emu) emu_ctrl_q <= dr_shift_q[3:0];
    end
  end

  // Output follows the falling edge so the far end samples a settled bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (!scan_on) begin
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= serial_bit;
      tdo_oe_q <= shifting;
    end
  end

  // Control bits: [0] pin a drives, [1] pin b drives, [2] a level, [3] b level
  wire off_cond = ~trst_s & pin_a_s & ~pin_b_s;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_q <= 1'b0;
      off_q <= 1'b0;
      a_out_q <= 1'b0;
      a_oe_q <= 1'b0;
      b_out_q <= 1'b0;
      b_oe_q <= 1'b0;
      a_seen_q <= 1'b0;
      b_seen_q <= 1'b0;
    end else begin
      scan_q <= scan_on;
      off_q <= off_cond;
      a_oe_q <= scan_on & emu_ctrl_q[0];
      b_oe_q <= scan_on & emu_ctrl_q[1];
      a_out_q <= emu_ctrl_q[2] | emu_event_a_send;
      b_out_q <= emu_ctrl_q[3] | emu_event_b_send;
      a_seen_q <= scan_on & ~emu_ctrl_q[0] & pin_a_s;
      b_seen_q <= scan_on & ~emu_ctrl_q[1] & pin_b_s;
    end
  end

  assign test_data_out = tdo_q;
  assign test_data_out_oe = tdo_oe_q;
  assign emulator_event_pin_a_out = a_out_q;
  assign emulator_event_pin_a_oe = a_oe_q;
  assign emulator_event_pin_b_output_disable_out = b_out_q;
  assign emulator_event_pin_b_output_disable_oe = b_oe_q;
  assign emu_event_a_seen = a_seen_q;
  assign emu_event_b_seen = b_seen_q;
  assign scan_control = scan_q;
  assign outputs_disabled = off_q;
endmodule

//--- dv/scan_test_port_sva.sv
// Concurrent checks on the scan test port pins
`timescale 1ns/100ps
module scan_test_port_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic test_reset,
  input wire logic test_clock,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  input wire logic emulator_event_pin_a_in,
  input wire logic emulator_event_pin_a_oe,
  input wire logic emulator_event_pin_b_output_disable_in,
  input wire logic scan_control,
  input wire logic outputs_disabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Two sync flops and a register: five steady cycles always cover the latency
  wire off_cond = !test_reset && emulator_event_pin_a_in &&
    !emulator_event_pin_b_output_disable_in;
  sequence scan_on_s; test_reset [*5]; endsequence
  sequence scan_off_s; !test_reset [*5]; endsequence
  sequence off_s; off_cond [*5]; endsequence
  sequence on_s; !off_cond [*5]; endsequence
  a_scan_ctrl_on: assert property (scan_on_s |-> scan_control) else $error("no scan");
  a_scan_ctrl_off: assert property (scan_off_s |-> !scan_control) else $error("scan");
  a_tdo_fall_only: assert property ($changed(test_data_out) |-> !$past(test_clock, 2))
    else $error("tdo moved");
  a_oe_on_fall: assert property ($rose(test_data_out_oe) |-> !$past(test_clock, 2))
    else $error("oe moved");
  a_idle_tdo_off: assert property (scan_off_s |-> !test_data_out_oe) else $error("oe");
  a_idle_emu_off: assert property (scan_off_s |-> !emulator_event_pin_a_oe) else $error("pin");
  a_off_set: assert property (off_s |-> outputs_disabled) else $error("not off");
  a_off_clear: assert property (on_s |-> !outputs_disabled) else $error("off");
endmodule

//--- dv/scan_ctrl_model.sv
// Scan controller model driving test clock, mode select and data input
`timescale 1ns/100ps
module scan_ctrl_model (
  input wire logic clk,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  output logic test_clock,
  output logic test_mode_select,
  output logic test_data_in
);
  logic last_q = 1'b0;
  // Released line toggles so a stale level can never pass as data
  wire tdo_line = test_data_out_oe ? test_data_out : ~last_q;
  initial {test_clock, test_mode_select, test_data_in} = 3'h2;
  always @(posedge clk) last_q <= tdo_line;
  // Four clocks per half period, above the three-clock minimum
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic m, input logic d, output logic q);
    test_mode_select = m;
    test_data_in = d;
    half();
    q = tdo_line;
    test_clock = 1'b1;
    half();
    test_clock = 1'b0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

//--- dv/scan_test_port_tb.sv
// Self-checking bench for the scan test port
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module scan_test_port_tb;
  import scan_port_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, test_reset = 1'b0, ext_a = 1'b0, ext_b = 1'b0;
  logic emu_event_a_send = 1'b0, emu_event_b_send = 1'b0, q;
  logic test_clock, test_mode_select, test_data_in, test_data_out, test_data_out_oe;
  logic emulator_event_pin_a_out, emulator_event_pin_a_oe, emu_event_a_seen, emu_event_b_seen;
  logic emulator_event_pin_b_output_disable_out, emulator_event_pin_b_output_disable_oe;
  logic scan_control, outputs_disabled;
  logic [31:0] got;
  int bad_count = 0, n_checks = 0, cyc = 0;
  wire emulator_event_pin_a_in = emulator_event_pin_a_oe ? emulator_event_pin_a_out : ext_a;
  wire emulator_event_pin_b_output_disable_in = emulator_event_pin_b_output_disable_oe ?
    emulator_event_pin_b_output_disable_out : ext_b;
  typedef struct {logic [3:0] c; int n; logic [31:0] d; logic [31:0] e;} row_s;
  row_s rows [5] = '{'{INS_IDCODE, 32, 32'h0, ID_VALUE},
    '{INS_USER_DATA, 32, 32'hC3A5_0F96, USER_DATA_RESET},
    '{INS_USER_DATA, 32, 32'h0, 32'hC3A5_0F96}, '{INS_BYPASS, 8, 32'hA5, 32'h4A},
    '{INS_EMU_CTRL, 4, 32'h5, 32'(EMU_CTRL_RESET)}};
  scan_test_port u_scan_test_port (.*);
  scan_ctrl_model u_scan_ctrl_model (.*);
  always #50 clk = ~clk;
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    test_reset = 1'b1;
    settle();
    `CHK(scan_control, 1'b1)
    u_scan_ctrl_model.step(1'b0, 1'b0, q);
    for (int r = 0; r < 5; r++) begin
      u_scan_ctrl_model.scan(1'b1, IR_WIDTH, 32'(rows[r].c), got);
      `CHK(got, 32'h1)
      u_scan_ctrl_model.scan(1'b0, rows[r].n, rows[r].d, got);
      `CHK(got, rows[r].e)
    end
    ext_b = 1'b1;
    emu_event_b_send = 1'b1;
    settle();
    `CHK(emulator_event_pin_a_in, 1'b1)
    `CHK(emu_event_b_seen, 1'b1)
    `CHK(emulator_event_pin_a_oe, 1'b1)
    `CHK(emulator_event_pin_b_output_disable_oe, 1'b0)
    `CHK(emulator_event_pin_b_output_disable_out, 1'b1)
    `CHK(emu_event_a_seen, 1'b0)
    `CHK(test_data_out_oe, 1'b0)
    {test_reset, ext_a, ext_b} = 3'h2;
    settle();
    `CHK(scan_control, 1'b0)
    `CHK(outputs_disabled, 1'b1)
    u_scan_ctrl_model.scan(1'b1, IR_WIDTH, 32'h0, got);
    `CHK(emulator_event_pin_a_oe, 1'b0)
    `CHK(test_data_out_oe, 1'b0)
    `CHK(emulator_event_pin_b_output_disable_oe, 1'b0)
    ext_b = 1'b1;
    emu_event_a_send = 1'b1;
    settle();
    `CHK(outputs_disabled, 1'b0)
    `CHK(emu_event_b_seen, 1'b0)
    `CHK(emulator_event_pin_a_out, 1'b1)
    {test_reset, ext_b} = 2'h2;
    settle();
    `CHK(outputs_disabled, 1'b0)
    summarize();
  end
endmodule
bind scan_test_port scan_test_port_sva u_scan_test_port_sva (
  .clk(clk),
  .arst_n(arst_n),
  .test_reset(test_reset),
  .test_clock(test_clock),
  .test_data_out(test_data_out),
  .test_data_out_oe(test_data_out_oe),
  .emulator_event_pin_a_in(emulator_event_pin_a_in),
  .emulator_event_pin_a_oe(emulator_event_pin_a_oe),
  .emulator_event_pin_b_output_disable_in(emulator_event_pin_b_output_disable_in),
  .scan_control(scan_control),
  .outputs_disabled(outputs_disabled)
);
